// ### dv/gpr_file_operand_addressing_tb.sv
// Purpose: self-checking bench for register file and operand forming.
// Assumes: 40 MHz clock; inputs change 1 ns after the rising edge.
// Notes: expected results wait in a queue until done_o shows them.
module gpr_file_operand_addressing_tb
	import gpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [15:0] ea; logic [47:0] op; logic [31:0] fo; logic [7:0] fx;
		logic fe, ce, co;} exp_type;
	logic clk_i = 0, rst_i = 1, req_i = 0, wr_en_i = 0, sp_step_i = 0, sp_down_i = 0;
	logic mode_b_i = 0, mem_ack_i;
	addr_mode_type mode_i = MODE_REG;
	data_fmt_type fmt_i = FMT_SINGLE, wr_fmt_i = FMT_SINGLE;
	logic [3:0] reg_i = 0, idx_i = 0, short_i = 0, wr_reg_i = 0;
	logic [1:0] base_sel_i = 0, mem_lat = 0;
	logic [7:0] disp_i = 0, fp_exp_o;
	logic [15:0] postword_i = 0, instruction_counter_i = 0, mem_data_i, ea_o, stack_ptr_o, mem_addr_o;
	logic [47:0] wr_data_i = 0, operand_o;
	logic [31:0] first_op_o;
	logic [4:0] sp_count_i = 0, mmu_count_i = 0, phys_addr_bits_o, mmu_units_o;
	logic busy_o, done_o, mc_phase_o, fetch_o, mem_rd_o, ext_wait_o, fault_mask_en_o, reload_regs_en_o;
	logic [15:0] rf [16];
	exp_type q [$];
	exp_type m_e;
	int num_errors = 0, checks = 0, cyc = 0, seed = 87986;

	gpr_file_operand_addressing #(.MMU_WAITS(1)) i_gpr_file_operand_addressing (
		.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .mode_i(mode_i), .fmt_i(fmt_i),
		.reg_i(reg_i), .idx_i(idx_i), .base_sel_i(base_sel_i), .disp_i(disp_i),
		.short_i(short_i), .postword_i(postword_i), .instruction_counter_i(instruction_counter_i),
		.wr_en_i(wr_en_i), .wr_reg_i(wr_reg_i), .wr_fmt_i(wr_fmt_i), .wr_data_i(wr_data_i),
		.sp_step_i(sp_step_i), .sp_down_i(sp_down_i), .sp_count_i(sp_count_i),
		.mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .mode_b_i(mode_b_i),
		.mmu_count_i(mmu_count_i), .busy_o(busy_o), .done_o(done_o), .mc_phase_o(mc_phase_o),
		.ea_o(ea_o), .operand_o(operand_o), .fetch_o(fetch_o), .first_op_o(first_op_o),
		.fp_exp_o(fp_exp_o), .stack_ptr_o(stack_ptr_o), .mem_rd_o(mem_rd_o),
		.mem_addr_o(mem_addr_o), .ext_wait_o(ext_wait_o), .fault_mask_en_o(fault_mask_en_o),
		.reload_regs_en_o(reload_regs_en_o), .phys_addr_bits_o(phys_addr_bits_o),
		.mmu_units_o(mmu_units_o)
	);
	mem_partner i_mem_partner (.clk_i(clk_i), .rd_i(mem_rd_o), .wait_i(ext_wait_o),
		.addr_i(mem_addr_o), .lat_i(mem_lat), .ack_o(mem_ack_i), .data_o(mem_data_i));

	// clock and hang guard
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			num_errors++;
			final_report;
		end
	end

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report;
		if (num_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// wait for an edge that takes requests
	task automatic to_phase;
		@(posedge clk_i);
		#1;
		while (mc_phase_o !== 1'b1)
		begin
			@(posedge clk_i);
			#1;
		end
	endtask

	task automatic wr(input logic [3:0] r, input data_fmt_type f, input logic [47:0] d);
		to_phase;
		wr_en_i = 1;
		wr_reg_i = r;
		wr_fmt_i = f;
		wr_data_i = d;
		@(posedge clk_i);
		#1;
		wr_en_i = 0;
		for (int k = 0; k <= int'(f); k++)
			rf[4'(r + k)] = d[47 - 16 * k -: 16];
	endtask

	task automatic op(input addr_mode_type m, input data_fmt_type f, input logic [3:0] r, x);
		exp_type e;
		logic [15:0] iv;
		to_phase;
		mode_i = m;
		fmt_i = f;
		reg_i = r;
		idx_i = x;
		postword_i = 16'($random(seed));
		instruction_counter_i = 16'($random(seed));
		base_sel_i = 2'($random(seed));
		iv = (x == 4'h0) ? 16'h0 : rf[x];
		e = '{postword_i + iv, 48'h0, 32'h0, 8'h0, 1'b0, 1'b1, 1'b0};
		case (m)
			MODE_REG:
			begin
				{e.ce, e.co} = 2'b01;
				e.op = {rf[r], f == FMT_SINGLE ? 16'h0 : rf[4'(r + 1)],
					f == FMT_EXT ? rf[4'(r + 2)] : 16'h0};
				e.fx = (f == FMT_SINGLE) ? 8'h0 : rf[4'(r + 1)][7:0];
			end
			MODE_DIRECT: e.fe = 1;
			MODE_INDIRECT: {e.fe, e.ea} = {1'b1, e.ea ^ 16'h5a5a};
			MODE_IMM_LONG: {e.ce, e.co, e.op} = {2'b01, e.ea, 32'h0};
			MODE_SHORT_POS: {e.ce, e.co, e.op} = {2'b01, 16'(short_i) + 16'h1, 32'h0};
			MODE_SHORT_NEG: {e.ce, e.co, e.op} = {2'b01, 16'h0 - 16'(short_i) - 16'h1, 32'h0};
			MODE_COUNTER_REL: e.ea = instruction_counter_i + 16'($signed(disp_i));
			default:
			begin
				e.fe = 1;
				e.ea = rf[4'hc + 4'(base_sel_i)] + ((m == MODE_BASE) ? {8'h0, disp_i} : iv);
				e.fo = (f == FMT_DOUBLE) ? {rf[0], rf[1]} : {rf[2], 16'h0};
			end
		endcase
		q.push_back(e);
		req_i = 1;
		@(posedge clk_i);
		#1;
		req_i = 0;
		while (done_o !== 1'b1)
		begin
			@(posedge clk_i);
			#1;
		end
	endtask

	// compare each finished request with the oldest expectation, mid-cycle when settled
	always @(negedge clk_i)
		if (done_o === 1'b1)
		begin
			m_e = q.pop_front();
			if (m_e.ce) check("ea", 48'(ea_o), 48'(m_e.ea));
			if (m_e.co) check("operand", operand_o, m_e.op);
			check("fetch", 48'(fetch_o), 48'(m_e.fe));
			check("first", 48'(first_op_o), 48'(m_e.fo));
			check("exponent", 48'(fp_exp_o), 48'(m_e.fx));
		end

	// main sequence
	initial
	begin
		repeat (5) @(posedge clk_i);
		#1;
		rst_i = 0;
		for (int i = 0; i < 16; i++)
			wr(4'(i), FMT_SINGLE, {16'($random(seed)), 32'h0});
		wr(4'hf, FMT_DOUBLE, {32'($random(seed)), 16'h0});
		// extended float with a normalised positive mantissa
		wr(4'he, FMT_EXT, {2'b01, 30'($random(seed)), 16'($random(seed))});
		for (int i = 0; i < 144; i++)
		begin
			disp_i = 8'($random(seed));
			short_i = 4'(i);
			mem_lat = 2'(i % 3);
			mmu_count_i = 5'(i % 2);
			op(addr_mode_type'(i % 9), data_fmt_type'((i / 9) % 3), 4'(13 + i),
				(i % 5 == 0) ? 4'h0 : 4'($random(seed)));
			if (i % 4 == 3)
				wr(4'($random(seed)), data_fmt_type'(i % 3), {$random(seed), 16'($random(seed))});
		end
		for (int i = 0; i < 6; i++)
		begin
			to_phase;
			{sp_step_i, sp_down_i, sp_count_i} = {1'b1, i[0], 5'($random(seed))};
			@(posedge clk_i);
			#1;
			sp_step_i = 0;
			rf[15] = sp_down_i ? rf[15] - 16'(sp_count_i) : rf[15] + 16'(sp_count_i);
			repeat (3) @(posedge clk_i);
			#1;
			check("stack", 48'(stack_ptr_o), 48'(rf[15]));
		end
		for (int i = 0; i < 8; i++)
		begin
			mode_b_i = i[0];
			mmu_count_i = (i < 2) ? 5'h0 : 5'($random(seed));
			repeat (2) @(posedge clk_i);
			#1;
			check("width", 48'(phys_addr_bits_o), 48'(mmu_count_i == 0 ? DIRECT_ADDR_BITS :
				mode_b_i ? MMU_B_ADDR_BITS : MMU_A_ADDR_BITS));
			check("units", 48'(mmu_units_o), 48'(mmu_count_i > 16 ? 5'h10 : mmu_count_i));
			check("mask", 48'({fault_mask_en_o, reload_regs_en_o}), 48'({2{mode_b_i}}));
		end
		final_report;
	end
endmodule

// ### dv/gpr_properties.sv
// Purpose: concurrent checks on the register file and operand former ports.
// Assumes: one clock domain, rst_i asynchronous and active high.
// Notes: bound to the top module; request fields are read at the taking edge.
module gpr_properties
	import gpr_pkg::*;
#(
	parameter int MMU_WAITS = 1
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// request and configuration inputs
	input wire logic req_i,
	input wire addr_mode_type mode_i,
	input wire logic [3:0] idx_i,
	input wire logic [7:0] disp_i,
	input wire logic [3:0] short_i,
	input wire logic [15:0] postword_i,
	input wire logic [15:0] instruction_counter_i,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_data_i,
	input wire logic mode_b_i,
	input wire logic [4:0] mmu_count_i,
	// outputs under watch
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic mc_phase_o,
	input wire logic [15:0] ea_o,
	input wire logic [47:0] operand_o,
	input wire logic fetch_o,
	input wire logic mem_rd_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic ext_wait_o,
	input wire logic fault_mask_en_o,
	input wire logic reload_regs_en_o,
	input wire logic [4:0] phys_addr_bits_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// request taken, then two busy clocks and a one-clock done
	sequence s_take;
		req_i && mc_phase_o && !busy_o && !done_o;
	endsequence
	sequence s_finish;
		busy_o && !done_o ##1 busy_o && !done_o ##1 done_o && !busy_o ##1 !done_o;
	endsequence

	a_phase_alternates: assert property (1 |=> mc_phase_o != $past(mc_phase_o))
		else $error("machine cycle phase did not alternate");
	a_two_cycle_op: assert property (s_take ##0 mode_i != MODE_INDIRECT |=> s_finish)
		else $error("operand request did not finish in one machine cycle");
	a_short_pos: assert property (s_take ##0 mode_i == MODE_SHORT_POS |=> ##2
		operand_o[47:32] == {12'h000, $past(short_i, 3)} + 16'h0001)
		else $error("short positive immediate wrong");
	a_short_neg: assert property (s_take ##0 mode_i == MODE_SHORT_NEG |=> ##2
		operand_o[47:32] == {12'hfff, ~$past(short_i, 3)})
		else $error("short negative immediate wrong");
	a_counter_rel: assert property (s_take ##0 mode_i == MODE_COUNTER_REL |=> ##2 !fetch_o &&
		ea_o == $past(instruction_counter_i, 3) + 16'($signed($past(disp_i, 3))))
		else $error("counter relative address wrong");
	a_direct_plain: assert property (s_take ##0 mode_i == MODE_DIRECT && idx_i == 4'h0 |=> ##2
		fetch_o && ea_o == $past(postword_i, 3))
		else $error("direct address without index wrong");
	a_imm_plain: assert property (s_take ##0 mode_i == MODE_IMM_LONG && idx_i == 4'h0 |=> ##2
		!fetch_o && operand_o[47:32] == $past(postword_i, 3))
		else $error("long immediate without index wrong");
	a_indirect_addr: assert property (mem_rd_o && $past(mem_rd_o) |->
		$stable(mem_addr_o) && busy_o && !ext_wait_o)
		else $error("indirect fetch address moved or fetch outside a request");
	a_indirect_return: assert property (mem_rd_o && mem_ack_i && !ext_wait_o |=>
		done_o && !mem_rd_o && ea_o == $past(mem_data_i))
		else $error("indirect word not used as address");
	a_wait_needs_mmu: assert property (ext_wait_o |-> mmu_count_i != 5'h00)
		else $error("wait state without a mapping unit");
	a_mode_b_regs: assert property (1 |=> fault_mask_en_o == $past(mode_b_i) &&
		reload_regs_en_o == $past(mode_b_i))
		else $error("mode b register presence wrong");
	a_space_width: assert property ($stable(mmu_count_i) && $stable(mode_b_i) |=>
		phys_addr_bits_o == ($past(mmu_count_i) == 5'h00 ? DIRECT_ADDR_BITS :
		$past(mode_b_i) ? MMU_B_ADDR_BITS : MMU_A_ADDR_BITS))
		else $error("physical address width wrong");
endmodule

bind gpr_file_operand_addressing gpr_properties #(.MMU_WAITS(MMU_WAITS)) i_gpr_properties (
	.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .mode_i(mode_i), .idx_i(idx_i),
	.disp_i(disp_i), .short_i(short_i), .postword_i(postword_i),
	.instruction_counter_i(instruction_counter_i), .mem_ack_i(mem_ack_i),
	.mem_data_i(mem_data_i), .mode_b_i(mode_b_i), .mmu_count_i(mmu_count_i),
	.busy_o(busy_o), .done_o(done_o), .mc_phase_o(mc_phase_o), .ea_o(ea_o),
	.operand_o(operand_o), .fetch_o(fetch_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
	.ext_wait_o(ext_wait_o), .fault_mask_en_o(fault_mask_en_o),
	.reload_regs_en_o(reload_regs_en_o), .phys_addr_bits_o(phys_addr_bits_o)
);

// ### dv/mem_partner.sv
// Purpose: bus sequencer stand-in answering indirect word fetches.
// Assumes: requests change only just after a rising edge.
// Notes: answer is the address folded with a fixed pattern.
module mem_partner
(
	// clock
	input wire logic clk_i,
	// fetch request from the block
	input wire logic rd_i,
	input wire logic wait_i,
	input wire logic [15:0] addr_i,
	input wire logic [1:0] lat_i,
	// answer
	output logic ack_o,
	output logic [15:0] data_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 0;

	// idle levels, then a one-clock answer after lat_i idle clocks; data churns otherwise
	initial
	begin
		ack_o = 1'b0;
		data_o = 16'h0000;
		forever
		begin
			@(posedge clk_i);
			#1;
			if (rd_i && !wait_i && !ack_o && cnt >= int'(lat_i))
			begin
				ack_o = 1'b1;
				data_o = addr_i ^ 16'h5a5a;
				cnt = 0;
			end
			else
			begin
				ack_o = 1'b0;
				data_o = ~data_o;
				cnt = (rd_i && !wait_i) ? cnt + 1 : 0;
			end
		end
	end
endmodule

// ### rtl/gpr_file_operand_addressing.sv
// Purpose: general register file with derived operand and address formation.
// Assumes: decoder and bus sequencer share clk_i; requests and acks are
//          sampled on machine cycle boundaries or clock edges as noted.
// Notes:   operands are left aligned, most significant word in bits 47:32.
module gpr_file_operand_addressing
	import gpr_pkg::*;
#(
	parameter int MMU_WAITS = MMU_WAIT_DEFAULT
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// operand request from the decoder
	input wire logic req_i,
	input wire addr_mode_type mode_i,
	input wire data_fmt_type fmt_i,
	input wire logic [3:0] reg_i,
	input wire logic [3:0] idx_i,
	input wire logic [1:0] base_sel_i,
	input wire logic [7:0] disp_i,
	input wire logic [3:0] short_i,
	input wire logic [15:0] postword_i,
	input wire logic [15:0] instruction_counter_i,
	// register write port
	input wire logic wr_en_i,
	input wire logic [3:0] wr_reg_i,
	input wire data_fmt_type wr_fmt_i,
	input wire logic [47:0] wr_data_i,
	// stack pointer adjust for multiple push and pop
	input wire logic sp_step_i,
	input wire logic sp_down_i,
	input wire logic [4:0] sp_count_i,
	// indirect word fetch from the bus sequencer
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_data_i,
	// configuration
	input wire logic mode_b_i,
	input wire logic [4:0] mmu_count_i,
	// request status
	output logic busy_o,
	output logic done_o,
	output logic mc_phase_o,
	// derived operand and address
	output logic [15:0] ea_o,
	output logic [47:0] operand_o,
	output logic fetch_o,
	output logic [31:0] first_op_o,
	output logic [7:0] fp_exp_o,
	output logic [15:0] stack_ptr_o,
	// indirect fetch request
	output logic mem_rd_o,
	output logic [15:0] mem_addr_o,
	output logic ext_wait_o,
	// architectural configuration
	output logic fault_mask_en_o,
	output logic reload_regs_en_o,
	output logic [4:0] phys_addr_bits_o,
	output logic [4:0] mmu_units_o
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CALC,
		ST_STRETCH,
		ST_FETCH,
		ST_DONE
	} fsm_type;

	fsm_type state_ff;
	fsm_type nxt_state;

	logic mc_en_ff;
	logic [15:0] gpr_ff [GPR_COUNT];

	// latched request
	addr_mode_type mode_ff;
	data_fmt_type fmt_ff;
	logic [3:0] reg_ff;
	logic [3:0] idx_ff;
	logic [1:0] bsel_ff;
	logic [7:0] disp_ff;
	logic [3:0] short_ff;
	logic [15:0] post_ff;
	logic [15:0] ic_ff;

	logic [7:0] wait_cnt_ff;
	logic busy_ff;
	logic done_ff;
	logic [15:0] ea_ff;
	logic [47:0] operand_ff;
	logic fetch_ff;
	logic [31:0] first_op_ff;
	logic [7:0] fp_exp_ff;
	logic [15:0] stack_ptr_ff;
	logic mem_rd_ff;
	logic ext_wait_ff;
	logic fault_mask_en_ff;
	logic reload_regs_en_ff;
	logic [4:0] phys_bits_ff;
	logic [4:0] mmu_units_ff;

	logic [3:0] base_reg;
	logic [15:0] idx_val;
	logic [15:0] base_val;
	logic [15:0] ea_calc;
	logic [15:0] imm_calc;
	logic [15:0] rd_w0;
	logic [15:0] rd_w1;
	logic [15:0] rd_w2;
	logic [47:0] reg_opnd;
	logic mmu_on;

	// machine cycle enable, one clock in two
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			mc_en_ff <= 1'b0;
		else
			mc_en_ff <= ~mc_en_ff;
	end

	// register reads for the current request
	assign base_reg = BASE_REG_FIRST + {2'b00, bsel_ff};
	assign idx_val = gpr_ff[idx_ff];
	assign base_val = gpr_ff[base_reg];
	assign rd_w0 = gpr_ff[reg_ff];
	assign rd_w1 = gpr_ff[wrap_reg(reg_ff, 2'd1)];
	assign rd_w2 = gpr_ff[wrap_reg(reg_ff, 2'd2)];
	assign mmu_on = (mmu_count_i != 5'h00);

	// assemble a register operand of one, two or three words
	always_comb
	begin
		case (fmt_ff)
			FMT_DOUBLE: reg_opnd = {rd_w0, rd_w1, 16'h0000};
			FMT_EXT: reg_opnd = {rd_w0, rd_w1, rd_w2};
			default: reg_opnd = {rd_w0, 32'h0000_0000};
		endcase
	end

	// address and immediate arithmetic
	operand_address_unit u_addr (
		.mode_i(mode_ff),
		.idx_i(idx_ff),
		.disp_i(disp_ff),
		.short_i(short_ff),
		.postword_i(post_ff),
		.icount_i(ic_ff),
		.idx_val_i(idx_val),
		.base_val_i(base_val),
		.ea_o(ea_calc),
		.imm_o(imm_calc)
	);

	// next state
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (mc_en_ff && req_i)
					nxt_state = ST_CALC;
			ST_CALC:
				if (mc_en_ff)
				begin
					if (mode_ff == MODE_INDIRECT && mmu_on)
						nxt_state = ST_STRETCH;
					else if (mode_ff == MODE_INDIRECT)
						nxt_state = ST_FETCH;
					else
						nxt_state = ST_DONE;
				end
			ST_STRETCH:
				if (mc_en_ff && wait_cnt_ff <= 8'd1)
					nxt_state = ST_FETCH;
			ST_FETCH:
				if (mem_ack_i)
					nxt_state = ST_DONE;
			ST_DONE:
				nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// request capture on a machine cycle boundary
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode_ff <= MODE_REG;
			fmt_ff <= FMT_SINGLE;
			reg_ff <= 4'h0;
			idx_ff <= 4'h0;
			bsel_ff <= 2'h0;
			disp_ff <= 8'h00;
			short_ff <= 4'h0;
			post_ff <= 16'h0000;
			ic_ff <= 16'h0000;
		end
		else if (state_ff == ST_IDLE && mc_en_ff && req_i)
		begin
			mode_ff <= mode_i;
			fmt_ff <= fmt_i;
			reg_ff <= reg_i;
			idx_ff <= idx_i;
			bsel_ff <= base_sel_i;
			disp_ff <= disp_i;
			short_ff <= short_i;
			post_ff <= postword_i;
			ic_ff <= instruction_counter_i;
		end
	end

	// wait state counter for expanded address formation
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			wait_cnt_ff <= 8'h00;
		else if (state_ff == ST_CALC)
			wait_cnt_ff <= 8'(MMU_WAITS);
		else if (state_ff == ST_STRETCH && mc_en_ff && wait_cnt_ff != 8'h00)
			wait_cnt_ff <= wait_cnt_ff - 8'h01;
	end

	// effective address: calculated, then replaced by the indirect word
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			ea_ff <= 16'h0000;
		else if (state_ff == ST_CALC && mc_en_ff)
			ea_ff <= ea_calc;
		else if (state_ff == ST_FETCH && mem_ack_i)
			ea_ff <= mem_data_i;
	end

	// derived operand and fetch flag
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			operand_ff <= 48'h0;
			fetch_ff <= 1'b0;
			fp_exp_ff <= 8'h00;
		end
		else if (state_ff == ST_CALC && mc_en_ff)
		begin
			case (mode_ff)
				MODE_REG: operand_ff <= reg_opnd;
				MODE_IMM_LONG,
				MODE_SHORT_POS,
				MODE_SHORT_NEG: operand_ff <= {imm_calc, 32'h0000_0000};
				default: operand_ff <= 48'h0;
			endcase
			fetch_ff <= (mode_ff == MODE_DIRECT || mode_ff == MODE_INDIRECT ||
				mode_ff == MODE_BASE || mode_ff == MODE_BASE_INDEXED);
			// float exponent sits in the low byte of the second word
			fp_exp_ff <= (mode_ff == MODE_REG && fmt_ff != FMT_SINGLE) ?
				rd_w1[EXP_W-1:0] : 8'h00;
		end
	end

	// implied first operand for base relative modes
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			first_op_ff <= 32'h0000_0000;
		else if (state_ff == ST_CALC && mc_en_ff)
		begin
			if (mode_ff != MODE_BASE && mode_ff != MODE_BASE_INDEXED)
				first_op_ff <= 32'h0000_0000;
			else if (fmt_ff == FMT_DOUBLE)
				first_op_ff <= {gpr_ff[DBL_IMPLIED_REG],
					gpr_ff[wrap_reg(DBL_IMPLIED_REG, 2'd1)]};
			else
				first_op_ff <= {gpr_ff[SGL_IMPLIED_REG], 16'h0000};
		end
	end

	// indirect fetch request and wait indication
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mem_rd_ff <= 1'b0;
			ext_wait_ff <= 1'b0;
		end
		else
		begin
			mem_rd_ff <= (nxt_state == ST_FETCH) && !(state_ff == ST_FETCH && mem_ack_i);
			ext_wait_ff <= (nxt_state == ST_STRETCH);
		end
	end

	// status
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			busy_ff <= (nxt_state != ST_IDLE) && (nxt_state != ST_DONE);
			done_ff <= (nxt_state == ST_DONE);
		end
	end

	// register file writes; a write to R15 beats a stack step
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < GPR_COUNT; i++)
				gpr_ff[i] <= 16'h0000;
		end
		else if (mc_en_ff)
		begin
			if (sp_step_i)
			begin
				if (sp_down_i)
					gpr_ff[STACK_REG] <= ea_sum(gpr_ff[STACK_REG],
						16'h0000 - {11'h000, sp_count_i});
				else
					gpr_ff[STACK_REG] <= ea_sum(gpr_ff[STACK_REG],
						{11'h000, sp_count_i});
			end
			if (wr_en_i)
			begin
				for (int k = 0; k < 3; k++)
				begin
					if (2'(k) < fmt_words(wr_fmt_i))
						gpr_ff[wrap_reg(wr_reg_i, 2'(k))] <=
							wr_data_i[47 - 16*k -: 16];
				end
			end
		end
	end

	// stack pointer view
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			stack_ptr_ff <= 16'h0000;
		else
			stack_ptr_ff <= gpr_ff[STACK_REG];
	end

	// architectural configuration from mode and MMU count
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fault_mask_en_ff <= 1'b0;
			reload_regs_en_ff <= 1'b0;
			phys_bits_ff <= DIRECT_ADDR_BITS;
			mmu_units_ff <= 5'h00;
		end
		else
		begin
			fault_mask_en_ff <= mode_b_i;
			reload_regs_en_ff <= mode_b_i;
			if (!mmu_on)
				phys_bits_ff <= DIRECT_ADDR_BITS;
			else if (mode_b_i)
				phys_bits_ff <= MMU_B_ADDR_BITS;
			else
				phys_bits_ff <= MMU_A_ADDR_BITS;
			mmu_units_ff <= (mmu_count_i > MAX_MMU_UNITS) ?
				MAX_MMU_UNITS : mmu_count_i;
		end
	end

	// outputs straight from flops
	assign busy_o = busy_ff;
	assign done_o = done_ff;
	assign mc_phase_o = mc_en_ff;
	assign ea_o = ea_ff;
	assign operand_o = operand_ff;
	assign fetch_o = fetch_ff;
	assign first_op_o = first_op_ff;
	assign fp_exp_o = fp_exp_ff;
	assign stack_ptr_o = stack_ptr_ff;
	assign mem_rd_o = mem_rd_ff;
	assign mem_addr_o = ea_ff;
	assign ext_wait_o = ext_wait_ff;
	assign fault_mask_en_o = fault_mask_en_ff;
	assign reload_regs_en_o = reload_regs_en_ff;
	assign phys_addr_bits_o = phys_bits_ff;
	assign mmu_units_o = mmu_units_ff;

endmodule

// ### rtl/gpr_pkg.sv
// Purpose: shared constants, types and helpers for the general register file
//          and operand address formation.
// Assumes: one 40 MHz clock; a machine cycle is two clock periods.
// Notes:   words are 16 bits; multi-word values are most significant word first.
package gpr_pkg;

	localparam int GPR_COUNT = 16;
	localparam int WORD_W = 16;
	localparam int REG_IDX_W = 4;
	localparam int DISP_W = 8;
	localparam int SHORT_W = 4;
	localparam int OPND_W = 48;
	localparam int FIRST_OP_W = 32;
	localparam int EXP_W = 8;

	// special register numbers
	localparam logic [3:0] INDEX_NONE = 4'h0;
	localparam logic [3:0] DBL_IMPLIED_REG = 4'h0;
	localparam logic [3:0] SGL_IMPLIED_REG = 4'h2;
	localparam logic [3:0] BASE_REG_FIRST = 4'hc;
	localparam logic [3:0] STACK_REG = 4'hf;

	// timing
	localparam int CLK_HZ = 40_000_000;
	localparam int CLKS_PER_MC = 2;
	localparam int MMU_WAIT_DEFAULT = 1;

	// address space widths in bits of word address
	localparam logic [4:0] DIRECT_ADDR_BITS = 5'h10;
	localparam logic [4:0] MMU_A_ADDR_BITS = 5'h14;
	localparam logic [4:0] MMU_B_ADDR_BITS = 5'h17;
	localparam logic [4:0] MAX_MMU_UNITS = 5'h10;

	typedef enum logic [3:0] {
		MODE_REG,
		MODE_DIRECT,
		MODE_INDIRECT,
		MODE_IMM_LONG,
		MODE_SHORT_POS,
		MODE_SHORT_NEG,
		MODE_COUNTER_REL,
		MODE_BASE,
		MODE_BASE_INDEXED
	} addr_mode_type;

	typedef enum logic [1:0] {
		FMT_SINGLE,
		FMT_DOUBLE,
		FMT_EXT
	} data_fmt_type;

	// register number k places after r, wrapping past fifteen
	function automatic logic [3:0] wrap_reg(input logic [3:0] r, input logic [1:0] k);
		wrap_reg = r + {2'b00, k};
	endfunction

	// sixteen-bit address sum, carry discarded
	function automatic logic [15:0] ea_sum(input logic [15:0] a, input logic [15:0] b);
		ea_sum = a + b;
	endfunction

	// number of registers a format occupies
	function automatic logic [1:0] fmt_words(input data_fmt_type f);
		case (f)
			FMT_DOUBLE: fmt_words = 2'd2;
			FMT_EXT: fmt_words = 2'd3;
			default: fmt_words = 2'd1;
		endcase
	endfunction

endpackage

// ### rtl/operand_address_unit.sv
// Purpose: combinational effective address and immediate operand former.
// Assumes: register values already read by the caller.
// Notes:   all sums wrap at sixteen bits.
module operand_address_unit
	import gpr_pkg::*;
(
	// instruction fields
	input wire addr_mode_type mode_i,
	input wire logic [3:0] idx_i,
	input wire logic [7:0] disp_i,
	input wire logic [3:0] short_i,
	input wire logic [15:0] postword_i,
	input wire logic [15:0] icount_i,
	// register values
	input wire logic [15:0] idx_val_i,
	input wire logic [15:0] base_val_i,
	// results
	output logic [15:0] ea_o,
	output logic [15:0] imm_o
);

	logic [15:0] idx_add;
	logic [15:0] post_idx;
	logic [15:0] disp_sext;
	logic [15:0] short_mag;

	// zero in the index field selects the unindexed form
	assign idx_add = (idx_i != INDEX_NONE) ? idx_val_i : 16'h0000;
	assign post_idx = ea_sum(postword_i, idx_add);
	assign disp_sext = {{8{disp_i[7]}}, disp_i};
	assign short_mag = {12'h000, short_i} + 16'h0001;

	// address per mode
	always_comb
	begin
		case (mode_i)
			MODE_DIRECT: ea_o = post_idx;
			MODE_INDIRECT: ea_o = post_idx;
			MODE_COUNTER_REL: ea_o = ea_sum(icount_i, disp_sext);
			MODE_BASE: ea_o = ea_sum(base_val_i, {8'h00, disp_i});
			MODE_BASE_INDEXED: ea_o = ea_sum(base_val_i, idx_add);
			default: ea_o = 16'h0000;
		endcase
	end

	// immediate operand per mode
	always_comb
	begin
		case (mode_i)
			MODE_IMM_LONG: imm_o = post_idx;
			MODE_SHORT_POS: imm_o = short_mag;
			MODE_SHORT_NEG: imm_o = 16'h0000 - short_mag;
			default: imm_o = 16'h0000;
		endcase
	end

endmodule
